/* pkg/dpk_map.vh */
`ifndef DPK_MAP_VH
`define DPK_MAP_VH
// register byte offsets
`define DPK_OFS_CTRL      8'h00
`define DPK_OFS_CTS_DLY   8'h04
`define DPK_OFS_HOLD      8'h08
`define DPK_OFS_KEYUP     8'h0C
`define DPK_OFS_DEKEY     8'h10
`define DPK_OFS_TOT       8'h14
`define DPK_OFS_MASK      8'h18
`define DPK_OFS_STATUS    8'h1C
`define DPK_OFS_EVENTS    8'h20
// control register bits
`define DPK_CTRL_KEYLINE  0
`define DPK_CTRL_KOD      1
`define DPK_CTRL_CONTINUOUS_KEY     2
`define DPK_CTRL_TOT_EN   3
`define DPK_CTRL_POL_HI   4
`define DPK_CTRL_TEST     5
`define DPK_CTRL_DEFAULTS 6
// status register bits
`define DPK_ST_CTS        0
`define DPK_ST_KEY        1
`define DPK_ST_ALARM      2
`define DPK_ST_TOT_LOCK   3
`define DPK_ST_HOLD_NA    4
`define DPK_ST_RELEASE    5
// reset and default values
`define DPK_RST_KEYLINE   1'b0
`define DPK_RST_KOD       1'b1
`define DPK_RST_CONTINUOUS_KEY      1'b0
`define DPK_RST_TOT_EN    1'b1
`define DPK_RST_POL_HI    1'b1
`define DPK_RST_TEST      1'b0
`define DPK_RST_CTS_DLY   8'h00
`define DPK_RST_HOLD      16'h0000
`define DPK_RST_KEYUP     8'h00
`define DPK_RST_DEKEY     8'h00
`define DPK_RST_TOT       8'h1E
`define DPK_RST_MASK      32'hFFFFFFFF
// timing
`define DPK_CLK_PERIOD_NS 25
`define DPK_MS_NS         1000000
`define DPK_MS_CYCLES     (`DPK_MS_NS / `DPK_CLK_PERIOD_NS)
`define DPK_SEC_MS        1000
`define DPK_HOLD_MAX      32'h0000EA60
`endif

/* src/dpk_ctrl.v */
// Notes on behaviour
// - 32-bit event mask lets only unmasked events drive the alarm output.
// - Event mask resets to all ones.
// - Mask bit n gates event status bit n.
// - Alarm output active level is set by alarm_polarity.
// - DCE mode: CTS rises a programmed 0-255 ms after RTS rises.
// - DCE with zero CTS delay: assert CTS at once on RTS; key after keyup_delay.
// - DCE is the default mode; CTS follows RTS after the delay.
// - DCE mode: CTS drops while the transmit buffer cannot take more.
// - Keyline: CTS on RF data at once, data held until delay ends.
// - Keyline with zero CTS delay: data passes without key-up wait.
// - Keyline: CTS held clear_hold_time after last character; zero drops.
// - RTS keys the transmitter in every mode.
// - key_on_data keys the transmitter after a full received character.
// - continuous_key keys permanently and disables the timeout timer.
// - Defaults: CTS 0, key_on_data on, DCE, delays 0, timeout on 30 s.
// - Test mode forces channel 0, ignoring channel select inputs.
// - Keying waits keyup_delay, 0-255 ms, after the key request.
// - Unkeying waits dekey_delay, 0-255 ms; zero unkeys at once.
// - Enabled timeout unkeys after 1-255 s of keying.
// - After timeout, no keying until the request has been withdrawn.
`timescale 1ns/100ps
`include "dpk_map.vh"

module dpk_ctrl #(
  parameter MS_CYCLES = `DPK_MS_CYCLES,
  parameter CHAN_W    = 4
) (
  // clock and reset
  input  wire              i_ref_clk,
  input  wire              i_sys_rst,
  // apb slave
  input  wire              i_psel,
  input  wire              i_penable,
  input  wire              i_pwrite,
  input  wire [7:0]        i_paddr,
  input  wire [31:0]       i_pwdata,
  output reg  [31:0]       o_prdata,
  output reg               o_pready,
  output reg               o_pslverr,
  // data port pins
  input  wire              i_rts,
  output reg               o_cts,
  // data port and radio logic
  input  wire              i_char_rx,
  input  wire              i_txbuf_empty,
  input  wire              i_txbuf_full,
  input  wire              i_rf_rx,
  input  wire              i_port_busy,
  output reg               o_rx_release,
  output reg               o_tx_key,
  // alarm
  input  wire [31:0]       i_alarm_events,
  output reg               o_alarm,
  // channel select
  input  wire [CHAN_W-1:0] i_chan_sel,
  output reg  [CHAN_W-1:0] o_chan
);

  ////////////////////////////////////////////////////////////////////////
  // registers
  reg              keyline;
  reg              key_on_data;
  reg              continuous_key;
  reg              tot_en;
  reg              alarm_polarity;
  reg              test_mode;
  reg [7:0]        cts_delay;
  reg [15:0]       clear_hold_time;
  reg [7:0]        keyup_delay;
  reg [7:0]        dekey_delay;
  reg [7:0]        tx_timeout_timer;
  reg [31:0]       alarm_event_mask;
  // synchronisers
  reg              rts_meta;
  reg              rts_s;
  reg [CHAN_W-1:0] chan_meta;
  reg [CHAN_W-1:0] chan_s;
  // timebase
  reg [31:0]       ms_div;
  reg              ms_tick;
  // keying state
  reg              data_key;
  reg              tot_lock;
  reg [7:0]        key_cnt;
  reg [9:0]        tot_ms;
  reg [7:0]        tot_sec;
  // handshake state
  reg [7:0]        cts_cnt;
  reg [15:0]       hold_cnt;
  reg              cts_kl;

  wire        apb_wr   = i_psel & i_penable & o_pready & i_pwrite;
  wire        defaults = apb_wr & (i_paddr == `DPK_OFS_CTRL) &
                         i_pwdata[`DPK_CTRL_DEFAULTS];
  wire        key_raw  = rts_s | (key_on_data & data_key) | continuous_key;
  wire        key_req  = key_raw & ~tot_lock;
  wire        tot_run  = tot_en & ~continuous_key;
  wire [7:0]  key_dly  = key_req ? keyup_delay : dekey_delay;
  wire        key_done = (key_cnt >= key_dly);
  wire        kl_act   = i_rf_rx | i_port_busy;
  wire        cts_trig = keyline ? (cts_kl | kl_act) : rts_s;
  wire        cts_done = (cts_cnt >= cts_delay);
  wire [31:0] alarm_hit = i_alarm_events & alarm_event_mask;
  reg  [31:0] next_prdata;
  reg         next_err;

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rts_meta  <= 1'b0;
      rts_s     <= 1'b0;
      chan_meta <= {CHAN_W{1'b0}};
      chan_s    <= {CHAN_W{1'b0}};
    end else begin
      rts_meta  <= i_rts;
      rts_s     <= rts_meta;
      chan_meta <= i_chan_sel;
      chan_s    <= chan_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // millisecond timebase
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ms_div  <= 32'h00000000;
      ms_tick <= 1'b0;
    end else if (ms_div >= MS_CYCLES - 1) begin
      ms_div  <= 32'h00000000;
      ms_tick <= 1'b1;
    end else begin
      ms_div  <= ms_div + 32'h00000001;
      ms_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb register file
  always @* begin
    next_prdata = 32'h00000000;
    next_err    = 1'b0;
    case (i_paddr)
      `DPK_OFS_CTRL: begin
        next_prdata[`DPK_CTRL_KEYLINE] = keyline;
        next_prdata[`DPK_CTRL_KOD]     = key_on_data;
        next_prdata[`DPK_CTRL_CONTINUOUS_KEY]    = continuous_key;
        next_prdata[`DPK_CTRL_TOT_EN]  = tot_en;
        next_prdata[`DPK_CTRL_POL_HI]  = alarm_polarity;
        next_prdata[`DPK_CTRL_TEST]    = test_mode;
      end
      `DPK_OFS_CTS_DLY: next_prdata[7:0]  = cts_delay;
      `DPK_OFS_HOLD:    next_prdata[15:0] = clear_hold_time;
      `DPK_OFS_KEYUP:   next_prdata[7:0]  = keyup_delay;
      `DPK_OFS_DEKEY:   next_prdata[7:0]  = dekey_delay;
      `DPK_OFS_TOT:     next_prdata[7:0]  = tx_timeout_timer;
      `DPK_OFS_MASK:    next_prdata       = alarm_event_mask;
      `DPK_OFS_STATUS: begin
        next_prdata[`DPK_ST_CTS]      = o_cts;
        next_prdata[`DPK_ST_KEY]      = o_tx_key;
        next_prdata[`DPK_ST_ALARM]    = o_alarm;
        next_prdata[`DPK_ST_TOT_LOCK] = tot_lock;
        next_prdata[`DPK_ST_HOLD_NA]  = ~keyline;
        next_prdata[`DPK_ST_RELEASE]  = o_rx_release;
      end
      `DPK_OFS_EVENTS:  next_prdata       = i_alarm_events;
      default:          next_err          = 1'b1;
    endcase
  end

  // pready rises in the access cycle, so every transfer has no wait state
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & next_err;
      if (i_psel & ~i_penable & ~i_pwrite)
        o_prdata <= next_prdata;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_sys_rst | defaults) begin
      keyline          <= `DPK_RST_KEYLINE;
      key_on_data      <= `DPK_RST_KOD;
      tot_en           <= `DPK_RST_TOT_EN;
      cts_delay        <= `DPK_RST_CTS_DLY;
      keyup_delay      <= `DPK_RST_KEYUP;
      dekey_delay      <= `DPK_RST_DEKEY;
      tx_timeout_timer <= `DPK_RST_TOT;
    end else if (apb_wr) begin
      case (i_paddr)
        `DPK_OFS_CTRL: begin
          keyline     <= i_pwdata[`DPK_CTRL_KEYLINE];
          key_on_data <= i_pwdata[`DPK_CTRL_KOD];
          tot_en      <= i_pwdata[`DPK_CTRL_TOT_EN];
        end
        `DPK_OFS_CTS_DLY: cts_delay   <= i_pwdata[7:0];
        `DPK_OFS_KEYUP:   keyup_delay <= i_pwdata[7:0];
        `DPK_OFS_DEKEY:   dekey_delay <= i_pwdata[7:0];
        `DPK_OFS_TOT:
          tx_timeout_timer <= (i_pwdata[7:0] == 8'h00) ? 8'h01 :
                              i_pwdata[7:0];
        default: ;
      endcase
    end
  end

  // settings that a defaults restore leaves alone
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      continuous_key   <= `DPK_RST_CONTINUOUS_KEY;
      alarm_polarity   <= `DPK_RST_POL_HI;
      test_mode        <= `DPK_RST_TEST;
      clear_hold_time  <= `DPK_RST_HOLD;
      alarm_event_mask <= `DPK_RST_MASK;
    end else if (apb_wr) begin
      case (i_paddr)
        `DPK_OFS_CTRL: begin
          // a restore write must not touch these bits
          if (~i_pwdata[`DPK_CTRL_DEFAULTS]) begin
            continuous_key <= i_pwdata[`DPK_CTRL_CONTINUOUS_KEY];
            alarm_polarity <= i_pwdata[`DPK_CTRL_POL_HI];
            test_mode      <= i_pwdata[`DPK_CTRL_TEST];
          end
        end
        `DPK_OFS_HOLD: begin
          // whole word is range checked, not only the stored bits
          if (i_pwdata <= `DPK_HOLD_MAX)
            clear_hold_time <= i_pwdata[15:0];
        end
        `DPK_OFS_MASK:  alarm_event_mask <= i_pwdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmitter keying
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      data_key <= 1'b0;
    end else if (i_char_rx) begin
      data_key <= 1'b1;
    end else if (i_txbuf_empty) begin
      data_key <= 1'b0;
    end
  end

  // key follows the request once the matching delay has run out
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_tx_key <= 1'b0;
      key_cnt  <= 8'h00;
    end else if (key_req == o_tx_key) begin
      key_cnt <= 8'h00;
    end else if (key_done) begin
      o_tx_key <= key_req;
      key_cnt  <= 8'h00;
    end else if (ms_tick) begin
      key_cnt <= key_cnt + 8'h01;
    end
  end

  // timeout timer and lockout
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      tot_ms   <= 10'h000;
      tot_sec  <= 8'h00;
      tot_lock <= 1'b0;
    end else begin
      if (~o_tx_key | ~tot_run) begin
        tot_ms  <= 10'h000;
        tot_sec <= 8'h00;
      end else if (ms_tick) begin
        if (tot_ms == `DPK_SEC_MS - 1) begin
          tot_ms  <= 10'h000;
          tot_sec <= tot_sec + 8'h01;
        end else begin
          tot_ms <= tot_ms + 10'h001;
        end
      end
      if (tot_run & o_tx_key & (tot_sec >= tx_timeout_timer))
        tot_lock <= 1'b1;
      else if (~key_raw & ~o_tx_key)
        tot_lock <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cts handshake
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cts_cnt <= 8'h00;
    end else if (~cts_trig) begin
      cts_cnt <= 8'h00;
    end else if (ms_tick & ~cts_done) begin
      cts_cnt <= cts_cnt + 8'h01;
    end
  end

  // keyline cts: set by rf data, held after the port goes idle
  always @(posedge i_ref_clk) begin
    if (i_sys_rst | ~keyline) begin
      cts_kl   <= 1'b0;
      hold_cnt <= 16'h0000;
    end else if (kl_act) begin
      cts_kl   <= 1'b1;
      hold_cnt <= 16'h0000;
    end else if (cts_kl) begin
      if (hold_cnt >= clear_hold_time)
        cts_kl <= 1'b0;
      else if (ms_tick)
        hold_cnt <= hold_cnt + 16'h0001;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_cts        <= 1'b0;
      o_rx_release <= 1'b1;
    end else if (keyline) begin
      o_cts        <= cts_kl | kl_act;
      o_rx_release <= cts_done;
    end else begin
      o_cts        <= rts_s & cts_done & ~i_txbuf_full;
      o_rx_release <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alarm and channel outputs
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_alarm <= ~`DPK_RST_POL_HI;
      o_chan  <= {CHAN_W{1'b0}};
    end else begin
      o_alarm <= alarm_polarity ? (|alarm_hit) : ~(|alarm_hit);
      o_chan  <= test_mode ? {CHAN_W{1'b0}} : chan_s;
    end
  end

endmodule // dpk_ctrl

/* test/dpk_monitor.sv */
`timescale 1ns/100ps
`include "dpk_map.vh"
module dpk_monitor #(
  parameter CHAN_W = 4
) (
  // clock, reset and apb
  input wire              i_ref_clk,
  input wire              i_sys_rst,
  input wire              i_psel,
  input wire              i_penable,
  input wire              i_pwrite,
  input wire [7:0]        i_paddr,
  input wire [31:0]       i_pwdata,
  input wire [31:0]       o_prdata,
  input wire              o_pready,
  input wire              o_pslverr,
  // port, radio and alarm
  input wire              i_txbuf_full,
  input wire              i_rf_rx,
  input wire [31:0]       i_alarm_events,
  input wire              o_cts,
  input wire              o_rx_release,
  input wire              o_tx_key,
  input wire              o_alarm,
  input wire [CHAN_W-1:0] o_chan
);
  logic [5:0]  ctl;
  logic [31:0] msk;
  wire         wr_acc = i_psel && i_penable && i_pwrite && o_pready;
  wire         act = (|(i_alarm_events & msk)) ^ !ctl[4];
  // shadow of control and mask, restore keeps key, polarity and test bits
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ctl <= 6'h1A;
      msk <= 32'hFFFFFFFF;
    end else if (wr_acc && i_paddr == `DPK_OFS_CTRL) begin
      ctl <= i_pwdata[6] ? (ctl & 6'h34) | 6'h0A : i_pwdata[5:0];
    end else if (wr_acc && i_paddr == `DPK_OFS_MASK) begin
      msk <= i_pwdata;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  sequence setup_s;
    i_psel && !i_penable;
  endsequence
  sequence full_s;
    i_txbuf_full && !ctl[0] ##1 i_txbuf_full && !ctl[0];
  endsequence
  sequence kl_rf_s;
    ctl[0] && i_rf_rx ##1 ctl[0] && i_rf_rx;
  endsequence
  chk_apb_answer: assert property (setup_s |=> o_pready)
    else $error("no ready after setup");
  chk_ready_single: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  chk_err_ready: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  chk_err_unmapped: assert property (
    setup_s and (i_paddr > 8'h20) |=> o_pslverr)
    else $error("unmapped access not refused");
  chk_mask_read: assert property (
    setup_s and (!i_pwrite && i_paddr == `DPK_OFS_MASK)
    |=> o_prdata == msk)
    else $error("mask readback wrong");
  chk_hold_na: assert property (
    setup_s and (!i_pwrite && i_paddr == `DPK_OFS_STATUS)
    |=> o_prdata[`DPK_ST_HOLD_NA] == !ctl[0])
    else $error("hold flag wrong");
  chk_alarm_level: assert property (
    !$past(i_sys_rst) |-> o_alarm == $past(act))
    else $error("alarm level wrong");
  chk_flow_cts: assert property (full_s |-> !o_cts)
    else $error("cts kept while buffer full");
  chk_keyline_cts: assert property (kl_rf_s |-> o_cts)
    else $error("cts missing on rf data");
  chk_test_chan: assert property ($past(ctl[5]) && ctl[5] |-> o_chan == 0)
    else $error("test mode channel not zero");
  chk_reset_out: assert property (
    $fell(i_sys_rst) |-> !o_cts && !o_tx_key && o_rx_release && !o_pready)
    else $error("outputs wrong after reset");
endmodule // dpk_monitor

/* test/dpk_dte.sv */
`timescale 1ns/100ps
module dpk_dte (
  // bench control
  input  wire  i_clk,
  input  wire  i_rts_req,
  input  wire  i_chr_req,
  // data port pins
  output logic o_rts  = 1'b0,
  output logic o_char = 1'b0
);
  // terminal raises rts to key, sends one-cycle character strobes
  always @(posedge i_clk) begin
    o_rts  <= i_rts_req;
    o_char <= i_chr_req;
  end
endmodule // dpk_dte

/* test/tb.sv */
`timescale 1ns/100ps
module tb;
  localparam MS = 4;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, e;
  logic [7:0]  pa = 0;
  logic [31:0] pwd = 0, prd, ev = 0, r;
  logic        prdy, perr, cts, rel, key, alm, rts, chr;
  logic        rts_req = 0, chr_req = 0, emp = 1, full = 0, rf = 0, busy = 0;
  logic [3:0]  sel = 0, chan;
  logic [31:0] rm [0:8];
  int          n_mismatch = 0, num_checks = 0, cyc = 0, n, i, k, k1;
  always #12.5 clk = ~clk;
  dpk_ctrl #(.MS_CYCLES(MS), .CHAN_W(4)) uut (.i_ref_clk(clk),
    .i_sys_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy),
    .o_pslverr(perr), .i_rts(rts), .o_cts(cts), .i_char_rx(chr),
    .i_txbuf_empty(emp), .i_txbuf_full(full), .i_rf_rx(rf),
    .i_port_busy(busy), .o_rx_release(rel), .o_tx_key(key),
    .i_alarm_events(ev), .o_alarm(alm), .i_chan_sel(sel), .o_chan(chan));
  dpk_dte dte (.i_clk(clk), .i_rts_req(rts_req), .i_chr_req(chr_req),
    .o_rts(rts), .o_char(chr));
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task cy(input int c);
    repeat (c) @(posedge clk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    t = 0;
    do @(posedge clk); while (prdy !== 1'b1 && ++t < 50);
    r = prd;
    e = perr;
    psel <= 0;
    pen <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
    case (a[5:2])
      0: if (d[6]) begin
        rm[0] = rm[0] & 32'h34 | 32'h0A;
        rm[1] = 0;
        rm[3] = 0;
        rm[4] = 0;
        rm[5] = 32'h1E;
      end else rm[0] = d & 32'h3F;
      1, 3, 4: rm[a[5:2]] = d & 32'hFF;
      2: if (d <= 60000) rm[2] = d;
      5: rm[5] = (d[7:0] == 0) ? 1 : d & 32'hFF;
      6: rm[6] = d;
    endcase
  endtask
  task rc(input logic [7:0] a);
    apb(0, a, 0);
    chk($sformatf("reg %h", a), rm[a[5:2]], r);
  endtask
  task meas(input int s, input logic v);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((s == 0 ? key : s == 1 ? cts : rel) !== v && n < 20000);
  endtask
  function logic inr(int c, int ms);
    return c >= (ms - 1) * MS && c <= (ms + 1) * MS + 4;
  endfunction
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      end_sim;
    end
  end
  initial begin
    rm = '{32'h1A, 0, 0, 0, 0, 32'h1E, 32'hFFFFFFFF, 32'h30, 0};
    void'($urandom(90391));
    cy(6);
    rst <= 0;
    for (i = 0; i < 9; i++) rc(8'(i * 4));
    apb(1, 8'h24, 1);
    chk("wr_err", 1, e);
    apb(0, 8'h24, 0);
    chk("rd_err", 1, e);
    chk("rd_zero", 0, r);
    for (k = 0; k < 3; k++) begin
      for (i = 1; i < 7; i++) wr(8'(i * 4), $urandom);
      wr(8'h08, $urandom % 60001);
      wr(8'h14, k);
      for (i = 1; i < 7; i++) rc(8'(i * 4));
    end
    wr(8'h00, 32'h40);
    for (i = 0; i < 7; i++) rc(8'(i * 4));
    $display("register test done");
    for (i = 0; i < 6; i++) begin
      wr(8'h00, {27'h0, i[0], 4'hA});
      ev <= i[1] ? ~rm[6] : $urandom;
      cy(3);
      chk("alarm", (|(ev & rm[6])) ^ !i[0], alm);
      rm[8] = ev;
      rc(8'h20);
    end
    ev <= 0;
    $display("alarm test done");
    rts_req <= 1;
    meas(1, 1);
    chk("cts_now", 1, n <= 5);
    chk("key_rts", 1, key);
    full <= 1;
    cy(3);
    chk("cts_full", 0, cts);
    full <= 0;
    rts_req <= 0;
    meas(0, 0);
    wr(8'h04, 5);
    wr(8'h0C, 2);
    wr(8'h10, 3);
    rts_req <= 1;
    meas(0, 1);
    k1 = n;
    chk("keyup", 1, inr(k1, 2));
    meas(1, 1);
    chk("cts_dly", 1, inr(k1 + n, 5));
    rts_req <= 0;
    meas(0, 0);
    chk("dekey", 1, inr(n, 3));
    wr(8'h0C, 0);
    wr(8'h10, 0);
    emp <= 0;
    chr_req <= 1;
    cy(1);
    chr_req <= 0;
    meas(0, 1);
    chk("kod", 1, n <= 6);
    emp <= 1;
    meas(0, 0);
    wr(8'h00, 32'h18);
    emp <= 0;
    chr_req <= 1;
    cy(1);
    chr_req <= 0;
    cy(10);
    chk("no_kod", 0, key);
    emp <= 1;
    $display("dce test done");
    wr(8'h00, 32'h19);
    wr(8'h04, 3);
    wr(8'h08, 6);
    rf <= 1;
    cy(3);
    chk("kl_cts", 1, cts);
    chk("kl_wait", 0, rel);
    meas(2, 1);
    chk("kl_rel", 1, inr(n + 3, 3));
    apb(0, 8'h1C, 0);
    chk("hold_na", 0, r[4]);
    rf <= 0;
    busy <= 1;
    cy(20);
    busy <= 0;
    meas(1, 0);
    chk("kl_hold", 1, inr(n, 6));
    wr(8'h08, 0);
    wr(8'h04, 0);
    rf <= 1;
    cy(3);
    chk("kl_nodly", 1, rel);
    rf <= 0;
    cy(3);
    chk("kl_drop", 0, cts);
    wr(8'h00, 32'h1A);
    sel <= 4'($urandom);
    cy(5);
    chk("chan", sel, chan);
    wr(8'h00, 32'h3A);
    sel <= ~sel;
    cy(3);
    chk("chan_test", 0, chan);
    wr(8'h00, 32'h1A);
    $display("keyline and channel test done");
    wr(8'h14, 1);
    rts_req <= 1;
    meas(0, 1);
    meas(0, 0);
    chk("timeout", 1, inr(n, 1000));
    cy(20);
    chk("tot_lock", 0, key);
    rts_req <= 0;
    cy(10);
    rts_req <= 1;
    meas(0, 1);
    chk("relock", 1, n <= 6);
    wr(8'h00, 32'h1E);
    cy(1100 * MS);
    chk("continuous_key", 1, key);
    rts_req <= 0;
    $display("timeout test done");
    end_sim;
  end
endmodule // tb
bind dpk_ctrl dpk_monitor #(.CHAN_W(CHAN_W)) u_mon (.i_ref_clk, .i_sys_rst,
  .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
  .o_pready, .o_pslverr, .i_txbuf_full, .i_rf_rx, .i_alarm_events,
  .o_cts, .o_rx_release, .o_tx_key, .o_alarm, .o_chan);
